// >>> rtl/gtr_defines.vh
// Constants for the gated timer: register indexes, fields, resets.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef GTR_DEFINES_VH
`define GTR_DEFINES_VH

// Register indexes; byte address on the bus is four times the index
`define GTR_IDX_COUNT      12'h0100
`define GTR_IDX_PERIOD     12'h0102
`define GTR_IDX_CONTROL    12'h0104
`define GTR_IDX_IRQ        12'h0106
`define GTR_IDX_OSC        12'h0108

// Control register fields
`define GTR_CTL_ON         15
`define GTR_CTL_SIDL       13
`define GTR_CTL_GATE       6
`define GTR_CTL_PS_HI      5
`define GTR_CTL_PS_LO      4
`define GTR_CTL_SYNC       2
`define GTR_CTL_CS         1
`define GTR_CTL_MASK       16'hA076

// Interrupt and oscillator register fields
`define GTR_IRQ_FLAG       0
`define GTR_IRQ_EN         1
`define GTR_OSC_LPEN       1

// Reset values
`define GTR_RST_COUNT      16'h0000
`define GTR_RST_PERIOD     16'hFFFF
`define GTR_RST_CONTROL    16'h0000

// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define GTR_PS_DIV1        8'h00
`define GTR_PS_DIV8        8'h07
`define GTR_PS_DIV64       8'h3F
`define GTR_PS_DIV256      8'hFF

`endif

// >>> rtl/gtr_edge_sync.v
// Two-flop synchroniser with edge detection for one pin.
// Assumes the pin is slow compared with mclk.
`timescale 1ns/1ps
`default_nettype none

module gtr_edge_sync (
  input  wire mclk,
  input  wire rst_n,
  input  wire pinIn,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // First flop feeds only the second; edges are seen on the later pair
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge strobes last one mclk cycle
  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule // gtr_edge_sync

`default_nettype wire

// >>> rtl/gtr_prescaler.v
// Selectable input prescaler, 1:1, 1:8, 1:64 or 1:256.
// Assumes tickIn is a one-cycle strobe in the mclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "gtr_defines.vh"

module gtr_prescaler (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [1:0] ratioSel,
  input  wire       clear,
  input  wire       tickIn,
  output wire       tickOut
);

  reg  [7:0] div_reg;
  wire [7:0] lastCount;

  // Terminal count for the selected ratio
  function [7:0] psLast;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    psLast = `GTR_PS_DIV1;
        2'd1:    psLast = `GTR_PS_DIV8;
        2'd2:    psLast = `GTR_PS_DIV64;
        default: psLast = `GTR_PS_DIV256;
      endcase
    end
  endfunction

  assign lastCount = psLast(ratioSel);
  assign tickOut   = tickIn & (div_reg >= lastCount);

  ////////////////////////////////////////////////////////////////////////
  // Counter clears on request; >= keeps a ratio change from stalling it
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
    end else if (clear) begin
      div_reg <= 8'h00;
    end else if (tickOut) begin
      div_reg <= 8'h00;
    end else if (tickIn) begin
      div_reg <= div_reg + 8'h01;
    end
  end

endmodule // gtr_prescaler

`default_nettype wire

// >>> rtl/gtr_timer.v
// Gated 16-bit timer with period match and real-time-clock mode.
// Assumes an AHB-Lite master, pins synchronous or slow to mclk, and
// an outside interrupt controller that takes timerIrq.
`timescale 1ns/1ps
`default_nettype none
`include "gtr_defines.vh"

module gtr_timer (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        extClkGatePin,
  input  wire        lowPowerOscOut,
  input  wire        cpuIdle,
  input  wire        cpuSleep,
  output reg         timerIrq,
  output reg         wakeEvent
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg  [15:0] count_reg;
  reg  [15:0] period_reg;
  reg  [15:0] control_reg;
  reg         irqFlag_reg;
  reg         irqEnable_reg;
  reg         low_power_osc_enable_reg;
  reg         wrPend_reg;
  reg  [11:0] wrIdx_reg;
  reg  [31:0] hrdata_next;

  wire        timerOn;
  wire        stopInIdle;
  wire        gateEnable;
  wire [1:0]  prescaleSel;
  wire        extSync;
  wire        clkSourceExt;

  wire        pinLevel;
  wire        pinRise;
  wire        pinFall;
  wire        oscRise;
  wire        addrPhase;
  wire        wrCount;
  wire        wrPeriod;
  wire        wrControl;
  wire        wrIrq;
  wire        wrOsc;
  wire        switchOff;
  wire        psClear;
  reg         tickIn;
  wire        incTick;
  wire        periodMatch;
  wire        gateEnd;

  assign timerOn      = control_reg[`GTR_CTL_ON];
  assign stopInIdle   = control_reg[`GTR_CTL_SIDL];
  assign gateEnable   = control_reg[`GTR_CTL_GATE];
  assign prescaleSel  = control_reg[`GTR_CTL_PS_HI:`GTR_CTL_PS_LO];
  assign extSync      = control_reg[`GTR_CTL_SYNC];
  assign clkSourceExt = control_reg[`GTR_CTL_CS];

  // Word index from byte address; word-aligned only
  function [11:0] wordIdx;
    input [31:0] addr;
    begin
      wordIdx = addr[13:2];
    end
  endfunction

  // True when the index names a register of this block
  function isMapped;
    input [11:0] idx;
    begin
      isMapped = (idx == `GTR_IDX_COUNT)   | (idx == `GTR_IDX_PERIOD) |
                 (idx == `GTR_IDX_CONTROL) | (idx == `GTR_IDX_IRQ) |
                 (idx == `GTR_IDX_OSC);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Edges reach the counter two to three cycles after the pin moves;
  // pulses shorter than one mclk cycle may be missed entirely.
  gtr_edge_sync uPinSync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pinIn (extClkGatePin),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  gtr_edge_sync uOscSync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pinIn (lowPowerOscOut),
    .level (),
    .rise  (oscRise),
    .fall  ()
  );

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  // No wait states keeps the slave small; every register is one flop
  // deep, so nothing here needs extra time to answer.
  // Non-word writes are dropped rather than merged into a half word.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel & htrans[1] & hready;

  // Capture the write address; data follows in the next cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 12'h000;
    end else begin
      wrPend_reg <= addrPhase & hwrite & (hsize == 3'b010);
      wrIdx_reg  <= wordIdx(haddr);
    end
  end

  assign wrCount   = wrPend_reg & (wrIdx_reg == `GTR_IDX_COUNT);
  assign wrPeriod  = wrPend_reg & (wrIdx_reg == `GTR_IDX_PERIOD);
  assign wrControl = wrPend_reg & (wrIdx_reg == `GTR_IDX_CONTROL);
  assign wrIrq     = wrPend_reg & (wrIdx_reg == `GTR_IDX_IRQ);
  assign wrOsc     = wrPend_reg & (wrIdx_reg == `GTR_IDX_OSC);

  // Read data is chosen in the address phase and registered for the
  // data phase; unmapped words read as zero
  // Limitation: a read placed in a write's data phase sees the old
  // value, since the write lands only at the end of that phase.
  always @* begin
    hrdata_next = 32'h0000_0000;
    if (isMapped(wordIdx(haddr))) begin
      case (wordIdx(haddr))
        `GTR_IDX_COUNT:   hrdata_next = {16'h0000, count_reg};
        `GTR_IDX_PERIOD:  hrdata_next = {16'h0000, period_reg};
        `GTR_IDX_CONTROL: hrdata_next = {16'h0000, control_reg};
        `GTR_IDX_IRQ:     hrdata_next = {30'h0000_0000, irqEnable_reg,
                                         irqFlag_reg};
        `GTR_IDX_OSC:     hrdata_next = {30'h0000_0000, low_power_osc_enable_reg, 1'b0};
        default:          hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase & ~hwrite) begin
      hrdata <= hrdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers; control write never touches the count
  // Unused control bits are masked on write so they always read zero
  // and cannot select a mode that the decoder does not know.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg   <= `GTR_RST_CONTROL;
      period_reg    <= `GTR_RST_PERIOD;
      irqEnable_reg <= 1'b0;
      low_power_osc_enable_reg   <= 1'b0;
    end else begin
      if (wrControl) begin
        control_reg <= hwdata[15:0] & `GTR_CTL_MASK;
      end
      if (wrPeriod) begin
        period_reg <= hwdata[15:0];
      end
      if (wrIrq) begin
        irqEnable_reg <= hwdata[`GTR_IRQ_EN];
      end
      if (wrOsc) begin
        low_power_osc_enable_reg <= hwdata[`GTR_OSC_LPEN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count source selection
  // External source is the pin, or the low-power oscillator once it is
  // enabled; internal and gated counting then stop, but a gate fall still sets the flag.
  // Sleep stops mclk-derived counting, so only async external survives.
  // Gating is only honoured with the internal source; with the external
  // source set the gate bit is ignored and the pin is a plain clock.
  always @* begin
    tickIn = 1'b0;
    if (!timerOn) begin
      tickIn = 1'b0;
    end else if (cpuIdle & stopInIdle) begin
      tickIn = 1'b0;
    end else if (cpuSleep & ~(clkSourceExt & ~extSync)) begin
      tickIn = 1'b0;
    end else if (clkSourceExt) begin
      if (low_power_osc_enable_reg) begin
        tickIn = oscRise;
      end else begin
        tickIn = pinRise;
      end
    end else if (low_power_osc_enable_reg) begin
      tickIn = 1'b0;
    end else if (gateEnable) begin
      tickIn = pinLevel;
    end else begin
      tickIn = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler clear: count write or switch-off, but only while running
  // since a halted prescaler simply holds its count
  // A count write while off therefore leaves the prescaler alone; the
  // switch-off already cleared it, so the first tick after switch-on takes a full prescale.
  assign switchOff = wrControl & timerOn & ~hwdata[`GTR_CTL_ON];
  assign psClear   = (wrCount & timerOn) | switchOff;

  gtr_prescaler uPrescaler (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ratioSel (prescaleSel),
    .clear    (psClear),
    .tickIn   (tickIn),
    .tickOut  (incTick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counter: load beats increment, match wraps to zero
  // Match is an equality test, so a count loaded above the period runs
  // on to 16'hFFFF and rolls over before it can match again.
  assign periodMatch = incTick & (count_reg == period_reg);
  assign gateEnd     = timerOn & gateEnable & ~clkSourceExt & pinFall;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `GTR_RST_COUNT;
    end else if (wrCount) begin
      count_reg <= hwdata[15:0];
    end else if (periodMatch) begin
      count_reg <= 16'h0000;
    end else if (incTick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flag: set wins over a write-one clear in the same cycle
  // Losing a match to a clear would hide an event from software, so a
  // clear that races a set must be repeated.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqFlag_reg <= 1'b0;
    end else if (periodMatch | gateEnd) begin
      irqFlag_reg <= 1'b1;
    end else if (wrIrq & hwdata[`GTR_IRQ_FLAG]) begin
      irqFlag_reg <= 1'b0;
    end
  end

  // Registered outputs: request level and one-cycle wake pulse
  // Registering costs one cycle of latency but keeps both outputs
  // glitch-free for the interrupt controller and the wake logic.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timerIrq  <= 1'b0;
      wakeEvent <= 1'b0;
    end else begin
      timerIrq  <= irqFlag_reg & irqEnable_reg;
      wakeEvent <= periodMatch & low_power_osc_enable_reg;
    end
  end

endmodule // gtr_timer

`default_nettype wire

// >>> bench/gtr_timer_monitor.sv
// Checker for the gated timer: bus answers and output timing.
// Assumes a single AHB-Lite master; bound to gtr_timer below.
`timescale 1ns/1ps
`default_nettype none
module gtr_timer_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timerIrq,
  input wire logic        wakeEvent
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Address phase of one word access
  sequence sq_acc(logic [31:0] a, logic w);
    hsel && htrans[1] && hready && haddr == a && hwrite == w
      && hsize == 3'b010;
  endsequence
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  chk_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_ctl_mask: assert property (sq_acc(32'h0000_0410, 1'b0)
    |=> (hrdata[15:0] & ~16'hA076) == 16'h0000)
    else $error("unused control bits read set");
  chk_unmapped_zero: assert property (sq_acc(32'h0000_0500, 1'b0)
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_irq_bits: assert property (sq_acc(32'h0000_0418, 1'b0)
    |=> hrdata[31:2] == 30'h0000_0000)
    else $error("irq register extra bits");
  // Clearing the enable must silence the request two edges later
  chk_irq_disable: assert property (sq_acc(32'h0000_0418, 1'b1)
    ##1 !hwdata[1] |=> ##1 !timerIrq)
    else $error("irq request with enable clear");
  // A wrap on the clearing edge may still pulse once; not after
  chk_wake_stop: assert property (sq_acc(32'h0000_0420, 1'b1)
    ##1 !hwdata[1] |=> ##1 !wakeEvent)
    else $error("wake event with osc enable clear");
endmodule // gtr_timer_monitor
bind gtr_timer gtr_timer_monitor mon_u (.mclk(mclk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timerIrq(timerIrq),
  .wakeEvent(wakeEvent));
`default_nettype wire

// >>> bench/gated_timer_with_rtc_mode_tb.sv
// Self-checking bench for gtr_timer over AHB-Lite.
// Assumes zero-wait slave; pins are slow against mclk.
`timescale 1ns/1ps
`default_nettype none
module gated_timer_with_rtc_mode_tb;
  localparam logic [31:0] CNT = 32'h0000_0400, PER = 32'h0000_0408;
  localparam logic [31:0] CTL = 32'h0000_0410, IRQ = 32'h0000_0418;
  localparam logic [31:0] OSC = 32'h0000_0420;
  logic        mclk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'b010;
  logic        extPin = 0, lpOsc = 0, cpuIdle = 0, cpuSleep = 0;
  wire         hreadyout, hresp, timerIrq, wakeEvent;
  logic        rdPend = 0;
  logic [31:0] expQ[$], seed = 32'h60cd, rv;
  int          fail_count = 0, num_checks = 0, cyc = 0, wakes = 0, d;
  gtr_timer dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .extClkGatePin(extPin),
    .lowPowerOscOut(lpOsc), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
    .timerIrq(timerIrq), .wakeEvent(wakeEvent));
  initial forever #2.5 mclk = ~mclk;
  ////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One single transfer; waits on hready in both phases
  task bus(input logic [31:0] a, input logic w, input logic [31:0] v);
    hsel <= 1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    hsel <= 0; htrans <= 2'b00; hwdata <= v;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
  endtask
  task wr(input logic [31:0] a, input logic [15:0] v);
    bus(a, 1'b1, {16'h0000, v});
  endtask
  task rd(input logic [31:0] a, input logic [15:0] e);
    expQ.push_back({16'h0000, e});
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  // Gate held high for n cycles, then settle past the synchroniser
  task gate(input int n);
    extPin <= 1;
    repeat (n) @(posedge mclk);
    extPin <= 0;
    repeat (8) @(posedge mclk);
  endtask
  task rises(input int n, input logic osc);
    repeat (n) begin
      if (osc) lpOsc <= 1; else extPin <= 1;
      repeat (4) @(posedge mclk);
      lpOsc <= 0; extPin <= 0;
      repeat (4) @(posedge mclk);
    end
  endtask
  ////////////////////////////////////////
  // Read results are matched against the oldest note
  always @(posedge mclk) begin
    if (rdPend) check(hrdata, expQ.pop_front());
    rdPend <= hsel && htrans[1] && !hwrite && hreadyout;
    if (wakeEvent) wakes++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim;
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    rd(CNT, 0); rd(PER, 16'hFFFF); rd(CTL, 0); rd(IRQ, 0);
    rd(32'h0000_0500, 0);
    repeat (3) begin
      rv = $random(seed);
      wr(CNT, rv[15:0]); rd(CNT, rv[15:0]);
    end
    wr(CTL, 16'h0076); rd(CTL, 16'h0076); rd(CNT, rv[15:0]);
    $display("test reset and registers done");
    wr(IRQ, 2);
    for (int r = 0; r < 4; r++) begin
      d = (r == 0) ? 1 : (r == 1) ? 8 : (r == 2) ? 64 : 256;
      wr(CTL, 16'h8040 | 16'(r << 4)); wr(CNT, 0);
      gate(d * 3 + d / 2); rd(CNT, 3);
      check(timerIrq, 1);
      wr(IRQ, 3);
      repeat (2) @(posedge mclk);
      check(timerIrq, 0);
    end
    $display("test gated prescaler done");
    wr(CTL, 16'hA040); wr(CNT, 0); cpuIdle <= 1;
    gate(10); rd(CNT, 0);
    wr(CTL, 16'h8040); rd(CNT, 0);
    gate(10); rd(CNT, 10); cpuIdle <= 0;
    wr(IRQ, 3);
    $display("test idle done");
    wr(PER, 2); wr(CTL, 16'h8002); wr(CNT, 0); cpuSleep <= 1;
    rises(3, 0); rd(CNT, 0); check(timerIrq, 1);
    wr(IRQ, 3); wr(CTL, 16'h8006); wr(CNT, 0);
    rises(2, 0); rd(CNT, 0); cpuSleep <= 0;
    rises(2, 0); rd(CNT, 2);
    $display("test sleep and counter done");
    wr(OSC, 2); wr(CTL, 16'h8002); wr(CNT, 0); wakes = 0;
    rises(2, 0); rd(CNT, 0);
    cpuSleep <= 1;
    rises(3, 1); rd(CNT, 0); check(wakes, 1);
    wr(CTL, 16'h8040); wr(CNT, 0);
    gate(6); rd(CNT, 0); cpuSleep <= 0;
    wr(OSC, 0); wr(IRQ, 0);
    $display("test rtc done");
    repeat (4) @(posedge mclk);
    end_sim;
  end
endmodule // gated_timer_with_rtc_mode_tb
`default_nettype wire
